// ### core/cdsr_regs.v
// Functional notes
// - four 16-bit oscillator counts, read-only, untouched by system reset
// - read-only RAM size in bytes, bits 1:0 read zero
// - saved status word captured on debugger entry, debug read-write
// - status bits: 0 events, 1 irq, 2 ev seq, 3 handler, 4 kernel, 10 asid
// - status bit 7 fast issue, bit 6 paused on event/lock/resource
// - bit 8 reads current issue mode; bit 9 writable kernel-entry issue mode
// - saved program counter captured as 32 bits on debugger entry
// - saved stack pointer captured as 32 bits on debugger entry
// - 8-bit thread select feeds first operand of debug register read
// - 5-bit register select feeds second operand of debug register read
// - 3-bit cause field, reset zero, codes one to five
// - 2-bit hit number, lowest wins, zero for host or debug call
// - 8-bit causing thread number, zero when host initiated
// - watchpoint address or resource id stored in interrupt data register
// - 8-bit stop mask halts flagged threads outside debug mode
// - eight scratch words shared with tile configuration path
// - four breakpoint addresses raise a debug request on matching pc
// - control bit 1 core oscillators, bit 0 peripheral, both reset zero
`timescale 1ns/1ps
`include "cdsr_defines.vh"
module cdsr_regs
#(
    parameter RAM_BYTES = 32'h0008_0000,
    parameter NUM_IBRK  = 4,
    parameter NUM_OSC   = 4
)
(
    // clock and resets
    input  wire                 I_CLK,
    input  wire                 I_RESETN,
    input  wire                 I_PORESETN,
    // status register access port
    input  wire                 I_PS_WR,
    input  wire                 I_PS_RD,
    input  wire [7:0]           I_PS_NUM,
    input  wire [31:0]          I_PS_WDATA,
    input  wire                 I_PS_DEBUG,
    output wire [31:0]          O_PS_RDATA,
    output reg                  O_PS_RVALID,
    // tile configuration scratch access
    input  wire                 I_CFG_WR,
    input  wire [2:0]           I_CFG_IDX,
    input  wire [31:0]          I_CFG_WDATA,
    output wire [31:0]          O_CFG_RDATA,
    // free-running oscillators: tile cell, tile wire, periph cell, wire
    input  wire [NUM_OSC-1:0]   I_OSC,
    output wire                 O_OSC_CORE_EN,
    output wire                 O_OSC_PERIPH_EN,
    // debugger entry capture
    input  wire                 I_DBG_ENTER,
    input  wire [2:0]           I_DBG_CAUSE,
    input  wire [7:0]           I_DBG_THREAD,
    input  wire [3:0]           I_DBG_HITS,
    input  wire [31:0]          I_DBG_INFO,
    input  wire [10:0]          I_DBG_SSW,
    input  wire [31:0]          I_DBG_SPC,
    input  wire [31:0]          I_DBG_SSP,
    input  wire                 I_ISSUE_MODE,
    input  wire                 I_IN_DEBUG,
    // instruction breakpoint compare
    input  wire                 I_PC_VALID,
    input  wire [31:0]          I_PC,
    input  wire [NUM_IBRK-1:0]  I_IBRK_EN,
    output reg  [NUM_IBRK-1:0]  O_IBRK_HITS,
    output reg                  O_IBRK_REQ,
    // debug register read operands and thread stop
    output wire [7:0]           O_DGR_THREAD,
    output wire [4:0]           O_DGR_REGNUM,
    output reg  [7:0]           O_THREAD_STOP
);

    // reset synchronisers
    reg         rst_s1_r;
    reg         rst_n_r;
    reg         por_s1_r;
    reg         por_n_r;

    always @(posedge I_CLK or negedge I_RESETN)
    begin
        if (!I_RESETN)
        begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // power-on reset only clears the counts; system reset leaves them
    always @(posedge I_CLK or negedge I_PORESETN)
    begin
        if (!I_PORESETN)
        begin
            por_s1_r <= 1'b0;
            por_n_r  <= 1'b0;
        end
        else
        begin
            por_s1_r <= 1'b1;
            por_n_r  <= por_s1_r;
        end
    end

    // register state
    reg [1:0]           osc_ctrl_r;
    reg [10:0]          ssw_r;
    reg [31:0]          spc_r;
    reg [31:0]          ssp_r;
    reg [7:0]           rd_thread_r;
    reg [4:0]           rd_reg_r;
    reg [2:0]           cause_r;
    reg [7:0]           cause_thread_r;
    reg [1:0]           hit_num_r;
    reg [31:0]          info_r;
    reg [7:0]           stop_mask_r;
    reg [31:0]          ibrk_addr_r [0:NUM_IBRK-1];
    reg [31:0]          rdata_r;
    reg                 scr_sel_r;

    wire        wr_any   = I_PS_WR;
    wire        dbg_wr   = I_PS_WR && I_PS_DEBUG;
    wire        is_scr   = I_PS_NUM >= `CDSR_SCRATCH_BASE &&
                           I_PS_NUM <= `CDSR_SCRATCH_LAST;
    wire        is_ibrk  = I_PS_NUM >= `CDSR_IBRK_BASE &&
                           I_PS_NUM <= `CDSR_IBRK_LAST;
    wire [1:0]  ibrk_idx = I_PS_NUM[1:0];
    wire [31:0] scr_rdata;

    // oscillator counters
    reg  [NUM_OSC-1:0]  osc_s1_r;
    reg  [NUM_OSC-1:0]  osc_s2_r;
    reg  [NUM_OSC-1:0]  osc_prev_r;
    reg  [15:0]         osc_cnt_r [0:NUM_OSC-1];

    assign O_OSC_CORE_EN   = osc_ctrl_r[`CDSR_OSC_CORE_BIT];
    assign O_OSC_PERIPH_EN = osc_ctrl_r[`CDSR_OSC_PERIPH_BIT];

    genvar g;
    generate
        for (g = 0; g < NUM_OSC; g = g + 1)
        begin : g_osc
            // first two belong to the core side, the rest to the periphery
            wire osc_en = (g < 2) ? osc_ctrl_r[`CDSR_OSC_CORE_BIT] :
                                    osc_ctrl_r[`CDSR_OSC_PERIPH_BIT];

            // no reset here: sync stages only hold oscillator samples
            always @(posedge I_CLK)
            begin
                osc_s1_r[g]   <= I_OSC[g];
                osc_s2_r[g]   <= osc_s1_r[g];
                osc_prev_r[g] <= osc_s2_r[g];
            end

            // counts rising edges seen at core rate, so the oscillator must
            // run below half the core clock or edges are dropped
            always @(posedge I_CLK or negedge por_n_r)
            begin
                if (!por_n_r)
                begin
                    osc_cnt_r[g] <= 16'h0000;
                end
                else if (osc_en && osc_s2_r[g] && !osc_prev_r[g])
                begin
                    osc_cnt_r[g] <= osc_cnt_r[g] + 16'h0001;
                end
            end
        end
    endgenerate

    // lowest-numbered hit wins
    reg [1:0] hit_low;
    always @*
    begin
        hit_low = 2'h0;
        if (I_DBG_HITS[0])
            hit_low = 2'h0;
        else if (I_DBG_HITS[1])
            hit_low = 2'h1;
        else if (I_DBG_HITS[2])
            hit_low = 2'h2;
        else if (I_DBG_HITS[3])
            hit_low = 2'h3;
    end

    wire cause_hw = I_DBG_CAUSE == `CDSR_CAUSE_IBRK   ||
                    I_DBG_CAUSE == `CDSR_CAUSE_DWATCH ||
                    I_DBG_CAUSE == `CDSR_CAUSE_RWATCH;
    wire cause_wp = I_DBG_CAUSE == `CDSR_CAUSE_DWATCH ||
                    I_DBG_CAUSE == `CDSR_CAUSE_RWATCH;

    // debug context: hardware capture wins over a same-cycle write
    always @(posedge I_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            osc_ctrl_r     <= `CDSR_OSC_CTRL_RESET;
            ssw_r          <= 11'h000;
            spc_r          <= 32'h0000_0000;
            ssp_r          <= 32'h0000_0000;
            rd_thread_r    <= 8'h00;
            rd_reg_r       <= 5'h00;
            cause_r        <= `CDSR_CAUSE_RESET;
            cause_thread_r <= 8'h00;
            hit_num_r      <= 2'h0;
            info_r         <= 32'h0000_0000;
            stop_mask_r    <= 8'h00;
        end
        else
        begin
            if (wr_any && I_PS_NUM == `CDSR_OSC_CTRL_NUM)
                osc_ctrl_r <= I_PS_WDATA[1:0];
            if (I_DBG_ENTER)
            begin
                ssw_r <= I_DBG_SSW;
                spc_r <= I_DBG_SPC;
                ssp_r <= I_DBG_SSP;
                cause_r <= I_DBG_CAUSE;
                cause_thread_r <= (I_DBG_CAUSE == `CDSR_CAUSE_HOST) ?
                                  8'h00 : I_DBG_THREAD;
                hit_num_r <= cause_hw ? hit_low : 2'h0;
                if (cause_wp)
                    info_r <= I_DBG_INFO;
            end
            else if (dbg_wr)
            begin
                case (I_PS_NUM)
                    `CDSR_SAVED_STATUS_NUM:
                        ssw_r <= (ssw_r & ~`CDSR_SSW_WR_MASK) |
                                 (I_PS_WDATA[10:0] &
                                  `CDSR_SSW_WR_MASK);
                    `CDSR_SAVED_PC_NUM:
                        spc_r <= I_PS_WDATA;
                    `CDSR_SAVED_SP_NUM:
                        ssp_r <= I_PS_WDATA;
                    `CDSR_IRQ_CAUSE_NUM:
                    begin
                        cause_r        <= I_PS_WDATA[2:0];
                        cause_thread_r <= I_PS_WDATA[15:8];
                        hit_num_r      <= I_PS_WDATA[17:16];
                    end
                    `CDSR_IRQ_INFO_NUM:
                        info_r <= I_PS_WDATA;
                    default:
                        ssw_r <= ssw_r;
                endcase
            end
            if (dbg_wr && I_PS_NUM == `CDSR_READ_THREAD_NUM)
                rd_thread_r <= I_PS_WDATA[7:0];
            if (dbg_wr && I_PS_NUM == `CDSR_READ_REG_NUM)
                rd_reg_r <= I_PS_WDATA[4:0];
            if (dbg_wr && I_PS_NUM == `CDSR_STOP_MASK_NUM)
                stop_mask_r <= I_PS_WDATA[7:0];
        end
    end

    assign O_DGR_THREAD = rd_thread_r;
    assign O_DGR_REGNUM = rd_reg_r;

    // breakpoint addresses and compare
    reg  [NUM_IBRK-1:0] hits_now;
    generate
        for (g = 0; g < NUM_IBRK; g = g + 1)
        begin : g_ibrk
            always @(posedge I_CLK or negedge rst_n_r)
            begin
                if (!rst_n_r)
                    ibrk_addr_r[g] <= 32'h0000_0000;
                else if (dbg_wr && is_ibrk && ibrk_idx == g)
                    ibrk_addr_r[g] <= I_PS_WDATA;
            end

            always @*
            begin
                hits_now[g] = I_PC_VALID && I_IBRK_EN[g] &&
                              I_PC == ibrk_addr_r[g];
            end
        end
    endgenerate

    // breakpoint request and thread stop outputs
    always @(posedge I_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            O_IBRK_HITS   <= {NUM_IBRK{1'b0}};
            O_IBRK_REQ    <= 1'b0;
            O_THREAD_STOP <= 8'h00;
        end
        else
        begin
            O_IBRK_HITS   <= hits_now;
            O_IBRK_REQ    <= |hits_now;
            // mask only bites once the debugger has returned
            O_THREAD_STOP <= I_IN_DEBUG ? 8'h00 : stop_mask_r;
        end
    end

    // scratch words, one array shared with the configuration path
    cdsr_scratch_mem #(
        .DEPTH      (8),
        .AW         (3),
        .DW         (32)
    ) u_scratch (
        .i_clk      (I_CLK),
        .i_a_we     (dbg_wr && is_scr),
        .i_a_addr   (I_PS_NUM[2:0]),
        .i_a_wdata  (I_PS_WDATA),
        .o_a_rdata  (scr_rdata),
        .i_b_we     (I_CFG_WR),
        .i_b_addr   (I_CFG_IDX),
        .i_b_wdata  (I_CFG_WDATA),
        .o_b_rdata  (O_CFG_RDATA)
    );

    // read mux; reserved and unmapped bits return zero
    reg [31:0] rd_nxt;
    always @*
    begin
        rd_nxt = 32'h0000_0000;
        case (I_PS_NUM)
            `CDSR_OSC_CTRL_NUM:
                rd_nxt[1:0] = osc_ctrl_r;
            `CDSR_TILE_CELL_NUM:
                rd_nxt[15:0] = osc_cnt_r[0];
            `CDSR_TILE_WIRE_NUM:
                rd_nxt[15:0] = osc_cnt_r[1];
            `CDSR_PERIPH_CELL_NUM:
                rd_nxt[15:0] = osc_cnt_r[2];
            `CDSR_PERIPH_WIRE_NUM:
                rd_nxt[15:0] = osc_cnt_r[3];
            `CDSR_RAM_SIZE_NUM:
                rd_nxt = {RAM_BYTES[31:2], 2'b00};
            `CDSR_SAVED_STATUS_NUM:
            begin
                rd_nxt[10:0] = ssw_r & `CDSR_SSW_WR_MASK;
                rd_nxt[`CDSR_SSW_ISSUE_BIT] = I_ISSUE_MODE;
            end
            `CDSR_SAVED_PC_NUM:
                rd_nxt = spc_r;
            `CDSR_SAVED_SP_NUM:
                rd_nxt = ssp_r;
            `CDSR_READ_THREAD_NUM:
                rd_nxt[7:0] = rd_thread_r;
            `CDSR_READ_REG_NUM:
                rd_nxt[4:0] = rd_reg_r;
            `CDSR_IRQ_CAUSE_NUM:
                rd_nxt = {14'h0000, hit_num_r, cause_thread_r,
                          5'h00, cause_r};
            `CDSR_IRQ_INFO_NUM:
                rd_nxt = info_r;
            `CDSR_STOP_MASK_NUM:
                rd_nxt[7:0] = stop_mask_r;
            default:
                rd_nxt = is_ibrk ? ibrk_addr_r[ibrk_idx] : 32'h0000_0000;
        endcase
    end

    always @(posedge I_CLK or negedge rst_n_r)
    begin
        if (!rst_n_r)
        begin
            rdata_r     <= 32'h0000_0000;
            scr_sel_r   <= 1'b0;
            O_PS_RVALID <= 1'b0;
        end
        else
        begin
            O_PS_RVALID <= I_PS_RD;
            if (I_PS_RD)
            begin
                rdata_r   <= rd_nxt;
                scr_sel_r <= is_scr;
            end
        end
    end

    // both sources are flops; the mux only picks the one read
    assign O_PS_RDATA = scr_sel_r ? scr_rdata : rdata_r;

endmodule

// ### core/cdsr_defines.vh
`ifndef CDSR_DEFINES_VH
`define CDSR_DEFINES_VH

// register numbers on the status register access port
`define CDSR_OSC_CTRL_NUM       8'h06
`define CDSR_TILE_CELL_NUM      8'h07
`define CDSR_TILE_WIRE_NUM      8'h08
`define CDSR_PERIPH_CELL_NUM    8'h09
`define CDSR_PERIPH_WIRE_NUM    8'h0A
`define CDSR_RAM_SIZE_NUM       8'h0C
`define CDSR_SAVED_STATUS_NUM   8'h10
`define CDSR_SAVED_PC_NUM       8'h11
`define CDSR_SAVED_SP_NUM       8'h12
`define CDSR_READ_THREAD_NUM    8'h13
`define CDSR_READ_REG_NUM       8'h14
`define CDSR_IRQ_CAUSE_NUM      8'h15
`define CDSR_IRQ_INFO_NUM       8'h16
`define CDSR_STOP_MASK_NUM      8'h18
`define CDSR_SCRATCH_BASE       8'h20
`define CDSR_SCRATCH_LAST       8'h27
`define CDSR_IBRK_BASE          8'h30
`define CDSR_IBRK_LAST          8'h33

// oscillator control fields
`define CDSR_OSC_CORE_BIT       1
`define CDSR_OSC_PERIPH_BIT     0
`define CDSR_OSC_CTRL_RESET     2'h0
`define CDSR_OSC_CNT_W          16

// saved status word fields
`define CDSR_SSW_W              11
`define CDSR_SSW_EVENTS_BIT     0
`define CDSR_SSW_IRQ_EN_BIT     1
`define CDSR_SSW_EV_SEQ_BIT     2
`define CDSR_SSW_IN_HANDLER_BIT 3
`define CDSR_SSW_KERNEL_BIT     4
`define CDSR_SSW_PAUSED_BIT     6
`define CDSR_SSW_FAST_BIT       7
`define CDSR_SSW_ISSUE_BIT      8
`define CDSR_SSW_ENTRY_ISSUE_BIT 9
`define CDSR_SSW_ASID_BIT       10
`define CDSR_SSW_WR_MASK        11'h6DF

// debug interrupt cause fields
`define CDSR_CAUSE_LSB          0
`define CDSR_CAUSE_MSB          2
`define CDSR_CAUSE_THREAD_LSB   8
`define CDSR_CAUSE_THREAD_MSB   15
`define CDSR_CAUSE_HITNUM_LSB   16
`define CDSR_CAUSE_HITNUM_MSB   17
`define CDSR_CAUSE_RESET        3'h0
`define CDSR_CAUSE_HOST         3'h1
`define CDSR_CAUSE_DEBUG_CALL_INSTR        3'h2
`define CDSR_CAUSE_IBRK         3'h3
`define CDSR_CAUSE_DWATCH       3'h4
`define CDSR_CAUSE_RWATCH       3'h5

// field widths
`define CDSR_THREAD_W           8
`define CDSR_REGSEL_W           5
`define CDSR_RAM_LOW_BITS       2

`endif

// ### core/cdsr_scratch_mem.v
`timescale 1ns/1ps
module cdsr_scratch_mem
#(
    parameter DEPTH  = 8,
    parameter AW     = 3,
    parameter DW     = 32
)
(
    // clock
    input  wire          i_clk,
    // port a: status register path, has write priority
    input  wire          i_a_we,
    input  wire [AW-1:0] i_a_addr,
    input  wire [DW-1:0] i_a_wdata,
    output reg  [DW-1:0] o_a_rdata,
    // port b: tile configuration path
    input  wire          i_b_we,
    input  wire [AW-1:0] i_b_addr,
    input  wire [DW-1:0] i_b_wdata,
    output reg  [DW-1:0] o_b_rdata
);

    reg [DW-1:0] mem_r [0:DEPTH-1];

    // one storage array behind both paths, so both see the same words
    always @(posedge i_clk)
    begin
        if (i_a_we)
        begin
            mem_r[i_a_addr] <= i_a_wdata;
        end
        if (i_b_we && !(i_a_we && i_a_addr == i_b_addr))
        begin
            mem_r[i_b_addr] <= i_b_wdata;
        end
        o_a_rdata <= mem_r[i_a_addr];
        o_b_rdata <= mem_r[i_b_addr];
    end

endmodule

// ### testbench/cdsr_checker.sv
`timescale 1ns/1ps
module cdsr_checker
#(
    parameter RAM_BYTES = 32'h0008_0000,
    parameter NUM_IBRK  = 4
)
(
    // clock and reset
    input wire                I_CLK,
    input wire                I_RESETN,
    // register port
    input wire                I_PS_WR,
    input wire                I_PS_RD,
    input wire [7:0]          I_PS_NUM,
    input wire [31:0]         I_PS_WDATA,
    input wire                I_PS_DEBUG,
    input wire [31:0]         O_PS_RDATA,
    input wire                O_PS_RVALID,
    // status and breakpoints
    input wire                I_ISSUE_MODE,
    input wire                I_IN_DEBUG,
    input wire                I_PC_VALID,
    input wire [NUM_IBRK-1:0] I_IBRK_EN,
    input wire [NUM_IBRK-1:0] O_IBRK_HITS,
    input wire                O_IBRK_REQ,
    // control outputs
    input wire                O_OSC_CORE_EN,
    input wire                O_OSC_PERIPH_EN,
    input wire [7:0]          O_DGR_THREAD,
    input wire [4:0]          O_DGR_REGNUM,
    input wire [7:0]          O_THREAD_STOP
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_RESETN);
    property p_rvalid; O_PS_RVALID == $past(I_PS_RD); endproperty
    a_rvalid: assert property (p_rvalid)
        else $error("read valid not one cycle after read");
    property p_ram;
        I_PS_RD && I_PS_NUM == 8'h0C |=> O_PS_RDATA == {RAM_BYTES[31:2], 2'b00};
    endproperty
    a_ram: assert property (p_ram) else $error("ram size wrong");
    property p_osc_rsvd;
        I_PS_RD && I_PS_NUM >= 8'h07 && I_PS_NUM <= 8'h0A
            |=> O_PS_RDATA[31:16] == 16'h0000;
    endproperty
    a_osc_rsvd: assert property (p_osc_rsvd)
        else $error("count upper bits set");
    property p_cause;
        I_PS_RD && I_PS_NUM == 8'h15
            |=> O_PS_RDATA[31:18] == 14'h0000 && O_PS_RDATA[7:3] == 5'h00;
    endproperty
    a_cause: assert property (p_cause)
        else $error("cause reserved set");
    property p_ssw;
        I_PS_RD && I_PS_NUM == 8'h10 |=> O_PS_RDATA[8] == $past(I_ISSUE_MODE)
            && O_PS_RDATA[31:11] == 21'h0 && !O_PS_RDATA[5];
    endproperty
    a_ssw: assert property (p_ssw) else $error("status word wrong");
    property p_stop_dbg; I_IN_DEBUG |=> O_THREAD_STOP == 8'h00; endproperty
    a_stop_dbg: assert property (p_stop_dbg)
        else $error("stop mask in debug");
    property p_stop_mask;
        I_PS_WR && I_PS_DEBUG && I_PS_NUM == 8'h18 ##1 !I_IN_DEBUG
            |=> {24'h0, O_THREAD_STOP} == ($past(I_PS_WDATA, 2) & 32'h0000_00FF);
    endproperty
    a_stop_mask: assert property (p_stop_mask)
        else $error("stop mask not applied");
    property p_nohit; !I_PC_VALID |=> !O_IBRK_REQ && !(|O_IBRK_HITS); endproperty
    a_nohit: assert property (p_nohit)
        else $error("hit without pc");
    property p_hit_en; (O_IBRK_HITS & ~$past(I_IBRK_EN)) == 0; endproperty
    a_hit_en: assert property (p_hit_en)
        else $error("disabled hit");
    property p_dgr;
        !(I_PS_WR && I_PS_DEBUG)
            |=> $stable(O_DGR_THREAD) && $stable(O_DGR_REGNUM);
    endproperty
    a_dgr: assert property (p_dgr)
        else $error("operand changed");
    property p_osc_en;
        !(I_PS_WR && I_PS_NUM == 8'h06)
            |=> $stable({O_OSC_CORE_EN, O_OSC_PERIPH_EN});
    endproperty
    a_osc_en: assert property (p_osc_en)
        else $error("enable changed");
    c_cause: cover property (I_PS_RD && I_PS_NUM == 8'h15);
    c_req: cover property (O_IBRK_REQ);
    c_stop: cover property (O_THREAD_STOP != 8'h00);
endmodule

bind cdsr_regs cdsr_checker #(.RAM_BYTES(RAM_BYTES), .NUM_IBRK(NUM_IBRK)) u_chk
(
    .I_CLK, .I_RESETN, .I_PS_WR, .I_PS_RD, .I_PS_NUM, .I_PS_WDATA,
    .I_PS_DEBUG, .O_PS_RDATA, .O_PS_RVALID, .I_ISSUE_MODE, .I_IN_DEBUG,
    .I_PC_VALID, .I_IBRK_EN, .O_IBRK_HITS, .O_IBRK_REQ, .O_OSC_CORE_EN,
    .O_OSC_PERIPH_EN, .O_DGR_THREAD, .O_DGR_REGNUM, .O_THREAD_STOP
);

// ### testbench/cdsr_osc_model.sv
`timescale 1ns/1ps
module cdsr_osc_model
(
    // run gate and group enables
    input  wire        i_run,
    input  wire        i_core_en,
    input  wire        i_periph_en,
    // oscillator levels and rising edge counts
    output wire [3:0]  o_osc,
    output wire [63:0] o_cnt
);
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : gen_osc
            reg        lvl;
            reg [15:0] cnt;
            // periods unrelated to the core clock, all slower than half rate
            initial
            begin
                lvl = 1'b0;
                cnt = 16'h0000;
                forever
                begin
                    #(310 + 60 * g);
                    if (i_run && (g < 2 ? i_core_en : i_periph_en))
                    begin
                        lvl = ~lvl;
                        cnt = cnt + lvl;
                    end
                    else
                        lvl = 1'b0;
                end
            end
            assign o_osc[g] = lvl;
            assign o_cnt[g*16 +: 16] = cnt;
        end
    endgenerate
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
    localparam [31:0] RAM = 32'h0004_0000;
    reg         clk, rstn, porn, ps_wr, ps_rd, ps_dbg, cfg_wr, enter;
    reg         issue, in_dbg, pc_v, run;
    reg  [7:0]  ps_num, d_thr;
    reg  [31:0] ps_wd, cfg_wd, d_info, d_spc, d_ssp, pc, e;
    reg  [2:0]  cfg_idx, d_cause;
    reg  [3:0]  d_hits, ibrk_en;
    reg  [10:0] d_ssw;
    reg  [1:0]  hit;
    wire [31:0] rdata, cfg_rd;
    wire        rvalid, core_en, per_en, req;
    wire [3:0]  osc, hits;
    wire [7:0]  dgr_t, stop;
    wire [4:0]  dgr_r;
    wire [63:0] ocnt;
    reg  [31:0] m [0:255];
    reg  [31:0] wm [0:255];
    integer     fail_count, checked, i, k;

    cdsr_regs #(.RAM_BYTES(RAM)) DUT (.I_CLK(clk), .I_RESETN(rstn),
        .I_PORESETN(porn), .I_PS_WR(ps_wr), .I_PS_RD(ps_rd), .I_PS_NUM(ps_num),
        .I_PS_WDATA(ps_wd), .I_PS_DEBUG(ps_dbg), .O_PS_RDATA(rdata),
        .O_PS_RVALID(rvalid), .I_CFG_WR(cfg_wr), .I_CFG_IDX(cfg_idx),
        .I_CFG_WDATA(cfg_wd), .O_CFG_RDATA(cfg_rd), .I_OSC(osc),
        .O_OSC_CORE_EN(core_en), .O_OSC_PERIPH_EN(per_en),
        .I_DBG_ENTER(enter), .I_DBG_CAUSE(d_cause), .I_DBG_THREAD(d_thr),
        .I_DBG_HITS(d_hits), .I_DBG_INFO(d_info), .I_DBG_SSW(d_ssw),
        .I_DBG_SPC(d_spc), .I_DBG_SSP(d_ssp), .I_ISSUE_MODE(issue),
        .I_IN_DEBUG(in_dbg), .I_PC_VALID(pc_v), .I_PC(pc), .I_IBRK_EN(ibrk_en),
        .O_IBRK_HITS(hits), .O_IBRK_REQ(req), .O_DGR_THREAD(dgr_t),
        .O_DGR_REGNUM(dgr_r), .O_THREAD_STOP(stop));
    cdsr_osc_model u_osc (.i_run(run), .i_core_en(core_en),
        .i_periph_en(per_en), .o_osc(osc), .o_cnt(ocnt));

    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task chk(input [31:0] got, input [31:0] exp);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask

    task summarize;
    begin
        if (fail_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask

    task wr(input [7:0] n, input [31:0] d, input dbg);
    begin
        @(posedge clk);
        ps_wr <= 1'b1;
        ps_num <= n;
        ps_wd <= d;
        ps_dbg <= dbg;
        @(posedge clk);
        ps_wr <= 1'b0;
        if (wm[n] != 0 && (dbg || n == 8'h06))
            m[n] = d & wm[n];
    end
    endtask

    task rd(input [7:0] n);
        reg [31:0] x;
    begin
        @(posedge clk);
        ps_rd <= 1'b1;
        ps_num <= n;
        issue <= $urandom;
        @(posedge clk);
        ps_rd <= 1'b0;
        x = m[n];
        if (n == 8'h10)
            x[8] = issue;
        if (n == 8'h0C)
            x = {RAM[31:2], 2'b00};
        if (n >= 8'h07 && n <= 8'h0A)
            x = ocnt[(n - 8'h07) * 16 +: 16];
        #1;
        chk(rdata, x);
    end
    endtask

    initial
    begin
        #2_000_000;
        fail_count = fail_count + 1;
        summarize;
    end

    initial
    begin
        void'($urandom(32'h4d8016f0));
        fail_count = 0;
        checked = 0;
        {ps_wr, ps_rd, ps_dbg, cfg_wr, enter, issue, in_dbg, pc_v, run} = 0;
        {ps_num, d_thr, ps_wd, cfg_wd, d_info, d_spc, d_ssp, pc} = 0;
        {cfg_idx, d_cause, d_hits, ibrk_en, d_ssw} = 0;
        rstn = 1'b0;
        porn = 1'b0;
        for (i = 0; i < 256; i = i + 1)
        begin
            m[i] = 0;
            wm[i] = (i >= 8'h20 && i <= 8'h27) || (i >= 8'h30 && i <= 8'h33)
                || i == 8'h11 || i == 8'h12 || i == 8'h16 ? 32'hFFFF_FFFF : 0;
        end
        wm[8'h06] = 32'h0000_0003;
        wm[8'h10] = 32'h0000_06DF;
        wm[8'h13] = 32'h0000_00FF;
        wm[8'h14] = 32'h0000_001F;
        wm[8'h15] = 32'h0003_FF07;
        wm[8'h18] = 32'h0000_00FF;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        porn <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 5; i <= 8'h18; i = i + 1)
            rd(i);
        // second pass runs outside debug mode and must leave the bank intact except the oscillator control at 0x06
        for (k = 0; k < 2; k = k + 1)
            for (i = 0; i < 256; i = i + 1)
                if (wm[i] != 0)
                begin
                    wr(i, $urandom, k == 0);
                    rd(i);
                end
        for (k = 1; k <= 5; k = k + 1)
        begin
            @(posedge clk);
            enter <= 1'b1;
            d_cause <= k;
            d_thr <= $urandom;
            d_hits <= k == 3 ? 4'b1010 : $urandom;
            {d_info, d_spc} <= {$urandom, $urandom};
            {d_ssp, d_ssw} <= {$urandom, $urandom};
            @(posedge clk);
            enter <= 1'b0;
            hit = 0;
            for (i = 3; i >= 0; i = i - 1)
                if (d_hits[i] && k >= 3)
                    hit = i;
            m[8'h10] = {21'h0, d_ssw} & wm[8'h10];
            m[8'h11] = d_spc;
            m[8'h12] = d_ssp;
            m[8'h15] = {14'h0, hit, k == 1 ? 8'h00 : d_thr, 5'h00, d_cause};
            if (k >= 4)
                m[8'h16] = d_info;
            for (i = 8'h10; i <= 8'h16; i = i + 1)
                rd(i);
        end
        for (k = 0; k < 2; k = k + 1)
        begin
            @(posedge clk) in_dbg <= k;
            wr(8'h18, $urandom, 1'b1);
            repeat (2) @(posedge clk);
            #1 chk(stop, k ? 8'h00 : m[8'h18][7:0]);
        end
        chk(dgr_t, m[8'h13][7:0]);
        chk(dgr_r, m[8'h14][4:0]);
        wr(8'h32, m[8'h30], 1'b1);
        for (k = 0; k < 4; k = k + 1)
        begin
            @(posedge clk);
            pc_v <= 1'b1;
            pc <= m[8'h30 + k];
            ibrk_en <= $urandom;
            @(posedge clk);
            pc_v <= 1'b0;
            #1 e = 0;
            for (i = 0; i < 4; i = i + 1)
                e[i] = ibrk_en[i] && m[8'h30 + i] == pc;
            chk(hits, e);
            chk(req, |e);
        end
        for (k = 0; k < 8; k = k + 1)
        begin
            @(posedge clk);
            cfg_wr <= 1'b1;
            cfg_idx <= k;
            cfg_wd <= $urandom;
            @(posedge clk);
            cfg_wr <= 1'b0;
            m[8'h20 + k] = cfg_wd;
            rd(8'h20 + k);
            wr(8'h20 + k, $urandom, 1'b1);
            @(posedge clk);
            #1 chk(cfg_rd, m[8'h20 + k]);
        end
        wr(8'h06, 3, 1'b0);
        @(posedge clk) run <= 1'b1;
        repeat (300) @(posedge clk);
        run <= 1'b0;
        // counts lag the oscillator through the sync stages
        repeat (12) @(posedge clk);
        wr(8'h06, 0, 1'b0);
        for (i = 7; i <= 10; i = i + 1)
            rd(i);
        @(posedge clk) rstn <= 1'b0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 8'h10; i <= 8'h18; i = i + 1)
            m[i] = 0;
        for (i = 6; i <= 10; i = i + 1)
            rd(i);
        rd(8'h15);
        summarize;
    end
endmodule
